// [include/als_defs.vh]
`ifndef ALS_DEFS_VH
`define ALS_DEFS_VH
// clock rate in cycles per millisecond (10 MHz)
`define CLK_PER_MS      10000
// integration period per channel, standard and extended range
`define STD_INT_MS      400
`define EXT_INT_MS      80
`define STD_INT_CYC     (`STD_INT_MS * `CLK_PER_MS)
`define EXT_INT_CYC     (`EXT_INT_MS * `CLK_PER_MS)
// bus stuck-low timeout, least and longest
`define TMO_MIN_MS      25
`define TMO_MAX_MS      35
`define TMO_CYC         (`TMO_MIN_MS * `CLK_PER_MS)
// fixed 7-bit slave address 0111001
`define SLV_ADDR        7'h39
// command byte values
`define CMD_RST         8'h00
`define CMD_PWR_DOWN    8'h00
`define CMD_PWR_UP      8'h03
`define CMD_EXT_RANGE   8'h1d
`define CMD_STD_RANGE   8'h18
`define CMD_RD_CH0      8'h43
`define CMD_RD_CH1      8'h83
// read source selection
`define SEL_CMD         2'h0
`define SEL_CH0         2'h1
`define SEL_CH1         2'h2
// result byte layout
`define RES_VALID_BIT   7
`define RES_RST         8'h00
// bits per byte on the wire
`define BYTE_BITS       4'h8
`endif

// [logic/light_converter.v]
`timescale 1ns/1ps
`include "als_defs.vh"

module light_converter #(
   parameter INT_W   = 23,
   parameter STD_CYC = `STD_INT_CYC,
   parameter EXT_CYC = `EXT_INT_CYC
)(
   input  wire       clk_sys,   // system clock
   input  wire       rst_b,     // synchronous reset, active low
   input  wire       run,       // converter powered up
   input  wire       ext,       // extended range selected
   input  wire       clr_valid, // pulse: power-up, drop valid flags
   input  wire [6:0] code0,     // channel 0 integrator code
   input  wire [6:0] code1,     // channel 1 integrator code
   output reg  [7:0] res0_r,    // channel 0 result register
   output reg  [7:0] res1_r     // channel 1 result register
);

   // last count of each period, cut to the counter width on purpose
   localparam [31:0]      STD_M1 = STD_CYC - 1;
   localparam [31:0]      EXT_M1 = EXT_CYC - 1;
   localparam [INT_W-1:0] STD_L  = STD_M1[INT_W-1:0];
   localparam [INT_W-1:0] EXT_L  = EXT_M1[INT_W-1:0];

   reg [INT_W-1:0] cnt_r;
   reg             ch_r;
   reg [6:0]       shadow_r;
   reg             xfer_r;
   reg             xfer_ch_r;
   wire [INT_W-1:0] lim;

   // range picks the period; a switch mid-integration takes effect at once
   assign lim = ext ? EXT_L : STD_L; // (R1) (R2) (R8)

   // integration timebase, channel 0 then channel 1, free running while up
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_r     <= {INT_W{1'b0}};
         ch_r      <= 1'b0;
         shadow_r  <= 7'h00;
         xfer_r    <= 1'b0;
         xfer_ch_r <= 1'b0;
      end else if (!run) begin
         cnt_r  <= {INT_W{1'b0}}; // (R23)
         ch_r   <= 1'b0;          // (R23)
         xfer_r <= 1'b0;
      end else if (cnt_r >= lim) begin
         cnt_r     <= {INT_W{1'b0}};            // (R6)
         shadow_r  <= ch_r ? code1 : code0;     // (R5)
         xfer_ch_r <= ch_r;
         xfer_r    <= 1'b1;
         ch_r      <= ~ch_r;                    // (R4)
      end else begin
         cnt_r  <= cnt_r + {{(INT_W-1){1'b0}}, 1'b1};
         xfer_r <= 1'b0;
      end
   end

   // second stage of the double buffer: whole byte lands in one edge
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         res0_r <= `RES_RST; // (R22)
         res1_r <= `RES_RST;
      end else begin
         if (clr_valid) begin
            res0_r[`RES_VALID_BIT] <= 1'b0; // (R22)
            res1_r[`RES_VALID_BIT] <= 1'b0;
         end
         if (xfer_r && !xfer_ch_r)
            res0_r <= {1'b1, shadow_r}; // (R7) (R10) (R21)
         if (xfer_r && xfer_ch_r)
            res1_r <= {1'b1, shadow_r}; // (R7) (R10) (R21)
      end
   end

endmodule // light_converter

// [logic/ambient_light_smbus_readout.v]
// How it works
// (R1) standard range integrates 400 ms per channel
// (R2) extended range integrates 80 ms per channel
// (R3) bus held low 25-35 ms aborts transfer
// (R4) channel 0 integrates first, then channel 1
// (R5) results move through a double buffer
// (R6) next conversion starts without host action
// (R7) valid flag set once result written
// (R8) extended range is one fifth the time
// (R9) 8-bit command register, writable and readable
// (R10) two read-only result registers, one per channel
// (R11) answer only slave address 0111001
// (R12) send byte writes the command register
// (R13) receive byte returns command or selected channel
// (R14) 0x00 powers down, 0x03 powers up
// (R15) 0x1d extended range, 0x18 standard range
// (R16) 0x43 selects channel 0, 0x83 channel 1
// (R17) command register resets to 0x00, powered down
// (R18) range holds until power-down or new range
// (R19) after 0x03 a read returns 0x03
// (R20) works with SMBus 1.1 and 2.0 hosts
// (R21) result byte: valid, segment, position
// (R22) no conversion yet means valid flag clear
// (R23) power-down halts; power-up restarts at channel 0
`timescale 1ns/1ps
`include "als_defs.vh"

module ambient_light_smbus_readout #(
   parameter INT_W   = 23,
   parameter STD_CYC = `STD_INT_CYC,
   parameter EXT_CYC = `EXT_INT_CYC,
   parameter TMO_W   = 19,
   parameter TMO_CYC = `TMO_CYC
)(
   input  wire       clk_sys,          // 10 MHz system clock
   input  wire       rst_b,            // synchronous reset, active low
   input  wire       serial_clock_pin, // bus clock from host
   input  wire       sda_in,           // bus data level seen on the pin
   output wire       sda_out,          // bus data drive value, always low
   output wire       sda_oe,           // high while pulling data low
   input  wire [6:0] ch0_code,         // channel 0 integrator code
   input  wire [6:0] ch1_code,         // channel 1 integrator code
   output wire       powered,          // converter powered up
   output wire       ext_range,        // extended range in force
   output wire [7:0] ch0_result,       // channel 0 result register
   output wire [7:0] ch1_result        // channel 1 result register
);

   // one-hot slave states
   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_ADDR = 8'h02;
   localparam [7:0] ST_ACKA = 8'h04;
   localparam [7:0] ST_WDAT = 8'h08;
   localparam [7:0] ST_ACKD = 8'h10;
   localparam [7:0] ST_RDAT = 8'h20;
   localparam [7:0] ST_RACK = 8'h40;
   localparam [7:0] ST_WAIT = 8'h80;

   // last watchdog count, cut to the counter width on purpose
   localparam [31:0]      TMO_M1 = TMO_CYC - 1;
   localparam [TMO_W-1:0] TMO_L  = TMO_M1[TMO_W-1:0];

   // pin synchronisers and filtered levels
   reg scl_s1_r;
   reg scl_s2_r;
   reg scl_s3_r;
   reg sda_s1_r;
   reg sda_s2_r;
   reg sda_s3_r;
   reg scl_f_r;
   reg sda_f_r;

   // slave engine
   reg [7:0]       st_r;
   reg [3:0]       bit_r;
   reg [7:0]       rx_r;
   reg [7:0]       tx_r;
   reg             rw_r;
   reg             drive_r;
   reg [TMO_W-1:0] tmo_r;

   // command side
   reg [7:0] cmd_r;
   reg [1:0] sel_r;
   reg       pwr_r;
   reg       ext_r;
   reg       clr_r;

   wire [7:0] res0;
   wire [7:0] res1;

   wire scl_ok;
   wire sda_ok;
   wire scl_rise;
   wire scl_fall;
   wire sda_rise;
   wire sda_fall;
   wire start_c;
   wire stop_c;
   wire tmo_hit;
   wire cmd_wr;
   wire sda_lvl;
   wire [7:0] rd_byte;

   // pick the byte a receive byte returns
   function [7:0] read_src;
      input [1:0] sel;
      input [7:0] cmd;
      input [7:0] r0;
      input [7:0] r1;
      begin
         case (sel)
            `SEL_CH0: read_src = r0;
            `SEL_CH1: read_src = r1;
            default:  read_src = cmd;
         endcase
      end
   endfunction

   // byte a receive byte would return right now
   assign rd_byte = read_src(sel_r, cmd_r, res0, res1);

   // three flops per pin; the first is only read by the second
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
      end else begin
         scl_s1_r <= serial_clock_pin;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
      end
   end

   // a level counts once the second and third flops agree
   assign scl_ok   = (scl_s2_r == scl_s3_r);
   assign sda_ok   = (sda_s2_r == sda_s3_r);
   assign scl_rise = scl_ok &  scl_s2_r & ~scl_f_r;
   assign scl_fall = scl_ok & ~scl_s2_r &  scl_f_r;
   assign sda_rise = sda_ok &  sda_s2_r & ~sda_f_r;
   assign sda_fall = sda_ok & ~sda_s2_r &  sda_f_r;
   // data level as of this edge: our own ack release can land with a clock rise
   assign sda_lvl  = sda_ok ? sda_s2_r : sda_f_r;

   // start and stop: data moves while the clock stays high
   assign start_c = sda_fall & scl_f_r & ~scl_fall; // (R20)
   assign stop_c  = sda_rise & scl_f_r & ~scl_fall;

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
      end else begin
         if (scl_ok)
            scl_f_r <= scl_s2_r;
         if (sda_ok)
            sda_f_r <= sda_s2_r;
      end
   end

   // stuck-low watchdog; only runs inside a transaction so an idle,
   // unpowered bus never trips it
   assign tmo_hit = (tmo_r == TMO_L); // (R3)

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         tmo_r <= {TMO_W{1'b0}};
      end else if (st_r == ST_IDLE || scl_rise || scl_fall || sda_rise || sda_fall) begin
         tmo_r <= {TMO_W{1'b0}};
      end else if ((!scl_f_r || !sda_f_r) && !tmo_hit) begin
         tmo_r <= tmo_r + {{(TMO_W-1){1'b0}}, 1'b1}; // (R3)
      end
   end

   // a send byte data phase completing with its own ack
   assign cmd_wr = (st_r == ST_WDAT) && scl_fall && (bit_r == `BYTE_BITS);

   // slave engine: bits sampled on clock rise, drive changed on clock fall
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         st_r    <= ST_IDLE;
         bit_r   <= 4'h0;
         rx_r    <= 8'h00;
         tx_r    <= 8'h00;
         rw_r    <= 1'b0;
         drive_r <= 1'b0;
      end else if (tmo_hit) begin
         st_r    <= ST_IDLE; // (R3)
         drive_r <= 1'b0;    // (R3)
      end else if (start_c) begin
         st_r    <= ST_ADDR; // repeated start restarts decoding
         bit_r   <= 4'h0;
         drive_r <= 1'b0;
      end else if (stop_c) begin
         st_r    <= ST_IDLE;
         drive_r <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               drive_r <= 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  rx_r  <= {rx_r[6:0], sda_lvl};
                  bit_r <= bit_r + 4'h1;
               end else if (scl_fall && bit_r == `BYTE_BITS) begin
                  if (rx_r[7:1] == `SLV_ADDR) begin // (R11)
                     rw_r    <= rx_r[0];
                     drive_r <= 1'b1; // address ack
                     st_r    <= ST_ACKA;
                  end else begin
                     st_r <= ST_WAIT; // (R11)
                  end
               end
            end
            ST_ACKA: begin
               if (scl_fall) begin
                  if (rw_r) begin
                     // byte frozen here, so a result update mid-read is unseen
                     tx_r    <= rd_byte;     // (R13)
                     drive_r <= ~rd_byte[7]; // (R13)
                     bit_r   <= 4'h1;
                     st_r    <= ST_RDAT;
                  end else begin
                     drive_r <= 1'b0;
                     bit_r   <= 4'h0;
                     st_r    <= ST_WDAT;
                  end
               end
            end
            ST_WDAT: begin
               if (scl_rise) begin
                  rx_r  <= {rx_r[6:0], sda_lvl};
                  bit_r <= bit_r + 4'h1;
               end else if (cmd_wr) begin
                  drive_r <= 1'b1; // data ack (R12)
                  st_r    <= ST_ACKD;
               end
            end
            ST_ACKD: begin
               if (scl_fall) begin
                  drive_r <= 1'b0;
                  st_r    <= ST_WAIT; // one byte per transaction (R12)
               end
            end
            ST_RDAT: begin
               if (scl_fall) begin
                  if (bit_r == `BYTE_BITS) begin
                     drive_r <= 1'b0; // let host ack or nack
                     st_r    <= ST_RACK;
                  end else begin
                     drive_r <= ~tx_r[6]; // open drain: drive only a zero
                     tx_r    <= {tx_r[6:0], 1'b0};
                     bit_r   <= bit_r + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise)
                  st_r <= ST_WAIT; // host ack is not needed for one byte
            end
            ST_WAIT: begin
               drive_r <= 1'b0;
            end
            default: begin
               st_r    <= ST_IDLE;
               drive_r <= 1'b0;
            end
         endcase
      end
   end

   // command register and its side effects; unknown bytes are stored only
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cmd_r <= `CMD_RST; // (R17)
         sel_r <= `SEL_CMD;
         pwr_r <= 1'b0;     // (R17)
         ext_r <= 1'b0;
         clr_r <= 1'b0;
      end else begin
         clr_r <= 1'b0;
         if (cmd_wr && !tmo_hit && !start_c && !stop_c) begin
            cmd_r <= rx_r; // (R9) (R12)
            case (rx_r)
               `CMD_PWR_DOWN: begin
                  pwr_r <= 1'b0;     // (R14)
                  ext_r <= 1'b0;     // (R18)
                  sel_r <= `SEL_CMD;
               end
               `CMD_PWR_UP: begin
                  pwr_r <= 1'b1;     // (R14)
                  clr_r <= ~pwr_r;   // (R22)
                  sel_r <= `SEL_CMD; // (R14) (R19)
               end
               `CMD_EXT_RANGE: begin
                  ext_r <= 1'b1;     // (R15) (R18)
               end
               `CMD_STD_RANGE: begin
                  ext_r <= 1'b0;     // (R15) (R18)
               end
               `CMD_RD_CH0: begin
                  sel_r <= `SEL_CH0; // (R16)
               end
               `CMD_RD_CH1: begin
                  sel_r <= `SEL_CH1; // (R16)
               end
               default: begin
                  sel_r <= sel_r;
               end
            endcase
         end
      end
   end

   // converter timebase and result registers
   light_converter #(
      .INT_W   (INT_W),
      .STD_CYC (STD_CYC),
      .EXT_CYC (EXT_CYC)
   ) u_conv (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .run       (pwr_r),
      .ext       (ext_r),
      .clr_valid (clr_r),
      .code0     (ch0_code),
      .code1     (ch1_code),
      .res0_r    (res0),
      .res1_r    (res1)
   );

   // outputs straight from flops, except sda_out, which is tied low
   assign sda_out    = 1'b0;
   assign sda_oe     = drive_r;
   assign powered    = pwr_r;
   assign ext_range  = ext_r;
   assign ch0_result = res0;
   assign ch1_result = res1;

endmodule // ambient_light_smbus_readout

// [sim/light_checker_properties.sv]
`timescale 1ns/1ps
module light_checker #(
   parameter int STD_CYC = 40,
   parameter int EXT_CYC = 8,
   parameter int TMO_CYC = 200
)(
   input wire       clk_sys,          // system clock
   input wire       rst_b,            // synchronous reset, active low
   input wire       serial_clock_pin, // bus clock
   input wire       sda_in,           // data wire level
   input wire       sda_out,          // data drive value
   input wire       sda_oe,           // data drive enable
   input wire [6:0] ch0_code,         // channel 0 code
   input wire [6:0] ch1_code,         // channel 1 code
   input wire       powered,          // converter on
   input wire       ext_range,        // extended range
   input wire [7:0] ch0_result,       // channel 0 result
   input wire [7:0] ch1_result        // channel 1 result
);
   logic [19:0] low_cnt_r;  // cycles the bus clock has sat low
   logic [7:0]  idle_cnt_r; // cycles since the bus clock last moved
   logic        scl_q_r;    // bus clock one cycle ago
   // both counters saturate so a long hold never wraps back into range
   always_ff @(posedge clk_sys) begin
      scl_q_r <= serial_clock_pin;
      if (!rst_b || serial_clock_pin)
         low_cnt_r <= 20'h0;
      else if (low_cnt_r != 20'hfffff)
         low_cnt_r <= low_cnt_r + 20'h1;
      if (!rst_b || serial_clock_pin != scl_q_r)
         idle_cnt_r <= 8'h0;
      else if (idle_cnt_r != 8'hff)
         idle_cnt_r <= idle_cnt_r + 8'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // a landing whose code stood still around the sampling point
   sequence s_ch0_land;
      $changed(ch0_result) && ch0_result[7] && $past(rst_b) && $past(ch0_code, 1) == $past(ch0_code, 4);
   endsequence
   AST_RESET_STATE: assert property ($rose(rst_b) |-> !powered && !ext_range && !sda_oe
      && ch0_result == 8'h00 && ch1_result == 8'h00) else $error("state after reset wrong");
   AST_HOLD_OFF: assert property ((!powered && $past(powered) == 1'b0 && $past(rst_b))
      |-> $stable(ch0_result) && $stable(ch1_result)) else $error("result moved while off");
   AST_VALID_CLR: assert property ($rose(powered) |-> ##[0:2]
      (ch0_result[7] == 1'b0 && ch1_result[7] == 1'b0)) else $error("valid not cleared");
   AST_CH0_FIRST: assert property ($rose(ch1_result[7]) |-> ch0_result[7])
      else $error("channel 1 valid before channel 0");
   AST_CH0_DATA: assert property (s_ch0_land |-> ch0_result[6:0] == $past(ch0_code, 2))
      else $error("channel 0 result differs from code");
   AST_TIMEOUT: assert property (low_cnt_r > TMO_CYC + 10 |-> !sda_oe)
      else $error("data still driven after clock timeout");
   AST_IDLE_STABLE: assert property ((idle_cnt_r > 8'd16 && $past(rst_b))
      |-> $stable(powered) && $stable(ext_range)) else $error("mode changed with bus idle");
   AST_DOWN_STD: assert property ($fell(powered) |-> !ext_range)
      else $error("power-down kept extended range");
   AST_VALID_STICKY: assert property (($fell(ch0_result[7]) || $fell(ch1_result[7]))
      && $past(rst_b) |-> $past(powered, 3) == 1'b0) else $error("valid dropped while on");
endmodule // light_checker

bind ambient_light_smbus_readout light_checker #(.STD_CYC(STD_CYC), .EXT_CYC(EXT_CYC),
   .TMO_CYC(TMO_CYC)) chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
   .serial_clock_pin(serial_clock_pin), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .ch0_code(ch0_code), .ch1_code(ch1_code), .powered(powered), .ext_range(ext_range),
   .ch0_result(ch0_result), .ch1_result(ch1_result));

// [sim/smbus_host.sv]
`timescale 1ns/1ps
module smbus_host (
   input  wire  clk_sys,  // pacing clock
   input  wire  sda_line, // resolved data wire, pulled up
   output logic scl_r,    // bus clock, stands high between frames
   output logic sda_r     // data drive, 1 releases the wire
);
   // idle bus: both lines released
   initial begin
      scl_r = 1'b1;
      sda_r = 1'b1;
   end
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // data moves only while the clock is low; read at the end of high
   task bit_io(input logic v, output logic s);
      sda_r = v;
      wt(2);
      scl_r = 1'b1;
      wt(4);
      s = sda_line;
      scl_r = 1'b0;
      wt(2);
   endtask
   task start();
      sda_r = 1'b0;
      wt(4);
      scl_r = 1'b0;
      wt(2);
   endtask
   task stop();
      sda_r = 1'b0;
      wt(2);
      scl_r = 1'b1;
      wt(4);
      sda_r = 1'b1;
      wt(8);
   endtask
   task put8(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
   endtask
   task get8(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
   endtask
   // one command byte per write transfer
   task send(input logic [6:0] a, input logic [7:0] c, output logic ack);
      logic s;
      start();
      put8({a, 1'b0});
      bit_io(1'b1, s);
      ack = !s;
      put8(c);
      bit_io(1'b1, s);
      ack = ack & !s;
      stop();
   endtask
   task recv(input logic [6:0] a, output logic [7:0] d, output logic ack);
      logic s;
      start();
      put8({a, 1'b1});
      bit_io(1'b1, s);
      ack = !s;
      get8(d);
      bit_io(1'b1, s); // host ends the read with a nack
      stop();
   endtask
endmodule // smbus_host

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam int STD_N = 40; // shortened standard integration
   localparam int EXT_N = 8;  // one fifth of standard
   logic       clk_sys;
   logic       rst_b;
   logic [6:0] ch0_code;
   logic [6:0] ch1_code;
   wire        scl_w;
   wire        host_sda;
   wire        sda_line;
   wire        sda_out;
   wire        sda_oe;
   wire        powered;
   wire        ext_range;
   wire [7:0]  ch0_result;
   wire [7:0]  ch1_result;
   int         error_cnt;
   int         checked;
   int         k;
   logic [7:0] rd;
   logic       ack;
   // open drain wire with pull-up: low while either side pulls
   assign sda_line = host_sda & (sda_oe ? sda_out : 1'b1);
   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;
   smbus_host host_u (.clk_sys(clk_sys), .sda_line(sda_line), .scl_r(scl_w), .sda_r(host_sda));
   ambient_light_smbus_readout #(.STD_CYC(STD_N), .EXT_CYC(EXT_N), .TMO_CYC(200)) dut_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .serial_clock_pin(scl_w), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .ch0_code(ch0_code), .ch1_code(ch1_code),
      .powered(powered), .ext_range(ext_range), .ch0_result(ch0_result), .ch1_result(ch1_result));
   task summarize();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task wr(input logic [7:0] c);
      host_u.send(7'h39, c, ack);
      chk("write ack", 8'h01, {7'h00, ack});
   endtask
   task rdchk(input logic [7:0] e);
      host_u.recv(7'h39, rd, ack);
      chk("read ack", 8'h01, {7'h00, ack});
      chk("read data", e, rd);
   endtask
   // bounded wait for a result byte; k counts the cycles spent
   task wait_res(input logic ch, input logic [7:0] e);
      k = 0;
      while ((ch ? ch1_result : ch0_result) !== e && k < 500) begin
         tick(1);
         k++;
      end
      if (k >= 500) begin
         error_cnt++;
         $display("[FAIL] result wait expected %h seen timeout", e);
         summarize();
      end
   endtask
   task t_reset();
      chk("flags", 8'h00, {5'h00, powered, ext_range, sda_oe});
      chk("res0", 8'h00, ch0_result);
      chk("res1", 8'h00, ch1_result);
      rdchk(8'h00);
   endtask
   task t_bad_addr();
      host_u.send(7'h38, 8'h03, ack);
      chk("foreign ack", 8'h00, {7'h00, ack});
      chk("powered", 8'h00, {7'h00, powered});
   endtask
   task t_power_up();
      wr(8'h03);
      chk("powered", 8'h01, {7'h00, powered});
      chk("valids", 8'h00, {ch0_result[7], ch1_result[7]});
      wait_res(1'b0, 8'ha5);
      chk("ch1 valid", 8'h00, {7'h00, ch1_result[7]});
      rdchk(8'h03);
   endtask
   // ch1 lands one integration period after ch0
   task t_period(input int n, input logic [6:0] c0, input logic [6:0] c1);
      ch0_code = c0;
      wait_res(1'b0, {1'b1, c0});
      ch1_code = c1;
      wait_res(1'b1, {1'b1, c1});
      chk("period", n[7:0], k[7:0]);
   endtask
   task t_ext();
      wr(8'h1d);
      chk("ext", 8'h01, {7'h00, ext_range});
      wr(8'h43);
      chk("ext kept", 8'h01, {7'h00, ext_range});
      rdchk(8'hb1);
      wr(8'h83);
      rdchk(8'hcc);
      t_period(EXT_N, 7'h11, 7'h7f);
   endtask
   task t_down();
      wr(8'h18);
      chk("ext", 8'h00, {7'h00, ext_range});
      wr(8'h00);
      chk("powered", 8'h00, {7'h00, powered});
      ch0_code = 7'h00;
      ch1_code = 7'h00;
      tick(3 * STD_N);
      chk("res0 held", 8'h91, ch0_result);
      chk("res1 held", 8'hff, ch1_result);
      rdchk(8'h00);
      wr(8'h03);
      chk("valids", 8'h00, {ch0_result[7], ch1_result[7]});
      wait_res(1'b0, 8'h80);
      chk("ch1 valid", 8'h00, {7'h00, ch1_result[7]});
   endtask
   // clock held low mid-transfer: the pending ack must be let go
   task t_timeout();
      host_u.start();
      host_u.put8(8'h72);
      tick(100);
      chk("ack held", 8'h01, {7'h00, sda_oe});
      tick(200);
      chk("released", 8'h00, {7'h00, sda_oe});
      host_u.stop();
      rdchk(8'h03);
   endtask
   initial begin
      error_cnt = 0;
      checked = 0;
      rst_b = 1'b0;
      ch0_code = 7'h25;
      ch1_code = 7'h5a;
      tick(3);
      rst_b = 1'b1;
      tick(5);
      t_reset();
      t_bad_addr();
      t_power_up();
      t_period(STD_N, 7'h31, 7'h4c);
      t_ext();
      t_down();
      t_timeout();
      summarize();
   end
endmodule // testbench
